// file: hw/twhc_pkg.sv
// Purpose: shared constants and types for the two-wire host control block
// Assumes: 125 MHz system clock, Avalon-MM register access
// Notes: register index n sits at byte address 4*n
package twhc_pkg;

  // ==========================================================
  // register indices (byte address is four times the index)
  localparam logic [5:0] IDX_DUAL = 6'h01;
  localparam logic [5:0] IDX_DBG = 6'h02;
  localparam logic [5:0] IDX_PRIM = 6'h03;
  localparam logic [5:0] IDX_SEC = 6'h04;
  localparam logic [5:0] IDX_STAT = 6'h05;
  localparam logic [5:0] IDX_ADDR = 6'h07;
  localparam logic [5:0] IDX_DATA = 6'h08;

  // ==========================================================
  // field positions
  localparam int DUAL_EN_BIT = 0;
  localparam int DUAL_PLUS_BIT = 1;
  localparam int DBG_RUN_BIT = 0;
  localparam int PRIM_EN_BIT = 0;
  localparam int PRIM_SMART_BIT = 1;
  localparam int PRIM_TO_LSB = 2;
  localparam int PRIM_QC_BIT = 4;
  localparam int PRIM_WRITE_IRQ_ENABLE_BIT = 6;
  localparam int PRIM_READ_IRQ_ENABLE_BIT = 7;
  localparam int SEC_ACK_BIT = 2;
  localparam int SEC_FLUSH_BIT = 3;
  localparam int STAT_WIF_BIT = 6;
  localparam int STAT_RIF_BIT = 7;
  localparam logic [7:0] RESET_VAL = 8'h00;

  // ==========================================================
  // command codes and bus states
  localparam logic [1:0] CMD_NONE = 2'h0;
  localparam logic [1:0] CMD_CMD_REPEATED_START = 2'h1;
  localparam logic [1:0] CMD_XFER = 2'h2;
  localparam logic [1:0] CMD_STOP = 2'h3;
  localparam logic [1:0] BUS_UNKNOWN = 2'h0;
  localparam logic [1:0] BUS_IDLE = 2'h1;
  localparam logic [1:0] BUS_OWNER = 2'h2;
  localparam logic [1:0] BUS_BUSY = 2'h3;

  // operations handed to the bit engine
  localparam logic [2:0] OP_START_ADDR = 3'h1;
  localparam logic [2:0] OP_WRITE = 3'h2;
  localparam logic [2:0] OP_ACK_READ = 3'h3;
  localparam logic [2:0] OP_ACK_CMD_REPEATED_START = 3'h4;
  localparam logic [2:0] OP_ACK_STOP = 3'h5;
  localparam logic [2:0] OP_ACK_ONLY = 3'h6;

  // ==========================================================
  // inactive-bus timeout, figures in microseconds
  localparam int CLK_MHZ = 125;
  localparam int TO1_US = 50;
  localparam int TO2_US = 100;
  localparam int TO3_US = 200;
  localparam int TO1_CYC = TO1_US * CLK_MHZ;
  localparam int TO2_CYC = TO2_US * CLK_MHZ;
  localparam int TO3_CYC = TO3_US * CLK_MHZ;

  // ==========================================================
  // carriers between this block and the bit engine
  typedef struct packed {
    logic [2:0] code;
    logic ack;
    logic [7:0] data;
  } twhc_op_t;

  typedef struct packed {
    logic addr_done;
    logic addr_acked;
    logic wr_done;
    logic rd_done;
    logic [7:0] rx_byte;
  } twhc_evt_t;

endpackage

// file: hw/twhc_top.sv
// Purpose: register bank and control logic of a two-wire bus host
// Assumes: bit engine on clk_i reports events; scl/sda are raw pins
// Notes: one-cycle Avalon answer; bus lines sampled through 2 flops
`timescale 1ns/1ps

// Notes on behaviour
// [R1] client plus-speed output follows its bit only while dual mode is on
// [R2] dual-mode enable bit turns on separate host and client paths
// [R3] with run bit clear, processor halt freezes the unit and its events
// [R4] read interrupt needs read flag, read enable and global enable
// [R5] write interrupt needs write flag, write enable and global enable
// [R6] quick command: acked address sets read or write flag by direction
// [R7] software ends quick command by writing stop command
// [R8] nonzero timeout field forces bus state idle after inactivity
// [R9] timeout codes: off, 50 us, 100 us, 200 us at 100 kHz
// [R10] smart mode sends stored ack choice right after data read
// [R11] host enable bit gates all bus operations
// [R12] flush clears host state and forces bus state idle
// [R13] flush write of one drops host enable for one clock cycle
// [R14] after flush address then data; start when scl found free
// [R15] ack choice zero sends ack, one sends nack
// [R16] ack action on smart data read or command, never data write
// [R17] command field is a write strobe and reads back zero
// [R18] codes: 1 ack then cmd_repeated_start, 3 ack then stop, 0 nothing
// [R19] code 2: write skips ack then writes; read acks then reads
// [R20] ack choice and command written together use the new ack
// [R21] address write starts and sends address, bit 0 is direction
// [R22] read flag on byte read; write flag on address or byte write
// [R23] interrupt requests are two separate level outputs
module twhc_top
  import twhc_pkg::*;
#(
  parameter int unsigned TO1_CYCLES = TO1_CYC,
  parameter int unsigned TO2_CYCLES = TO2_CYC,
  parameter int unsigned TO3_CYCLES = TO3_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic cpu_halted_i,
  input wire logic global_irq_en_i,
  input wire twhc_evt_t eng_evt_i,
  output twhc_op_t op_o,
  output logic op_valid_o,
  output logic host_enable_o,
  output logic dual_enable_o,
  output logic client_plus_speed_o,
  output logic read_irq_o,
  output logic write_irq_o,
  output logic [1:0] bus_state_o
);

  // ==========================================================
  // register access decode
  logic [5:0] idx;
  logic [7:0] wd;
  logic acc_wr;
  logic acc_rd;
  assign idx = avs_address_i[7:2];
  assign wd = avs_writedata_i[7:0];
  // only lane 0 carries register bits, so only it commits a write
  assign acc_wr = avs_write_i & ~avs_waitrequest_o & avs_byteenable_i[0];
  assign acc_rd = avs_read_i & ~avs_waitrequest_o;

  function automatic logic wr_to(input logic [5:0] k);
    wr_to = acc_wr && (idx == k);
  endfunction

  // ==========================================================
  // control registers
  logic dual_en, plus_sel, run_halted;
  logic host_en, smart_en, qc_en, read_irq_enable, write_irq_enable, ack_sel;
  logic [1:0] to_sel;
  logic [7:0] addr_q;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      dual_en <= RESET_VAL[0];
      plus_sel <= RESET_VAL[0];
      run_halted <= RESET_VAL[0];
      host_en <= RESET_VAL[0];
      smart_en <= RESET_VAL[0];
      qc_en <= RESET_VAL[0];
      to_sel <= RESET_VAL[1:0];
      read_irq_enable <= RESET_VAL[0];
      write_irq_enable <= RESET_VAL[0];
      ack_sel <= RESET_VAL[0];
      addr_q <= RESET_VAL;
    end else begin
      if (wr_to(IDX_DUAL)) begin
        dual_en <= wd[DUAL_EN_BIT]; // R2
        plus_sel <= wd[DUAL_PLUS_BIT];
      end
      if (wr_to(IDX_DBG)) begin
        run_halted <= wd[DBG_RUN_BIT];
      end
      if (wr_to(IDX_PRIM)) begin
        host_en <= wd[PRIM_EN_BIT]; // R11
        smart_en <= wd[PRIM_SMART_BIT];
        to_sel <= wd[PRIM_TO_LSB+1:PRIM_TO_LSB]; // R8
        qc_en <= wd[PRIM_QC_BIT];
        write_irq_enable <= wd[PRIM_WRITE_IRQ_ENABLE_BIT];
        read_irq_enable <= wd[PRIM_READ_IRQ_ENABLE_BIT];
      end
      if (wr_to(IDX_SEC)) begin
        ack_sel <= wd[SEC_ACK_BIT]; // R15
      end
      if (wr_to(IDX_ADDR)) begin
        addr_q <= wd; // R21
      end
    end
  end

  // ==========================================================
  // halt gating and software triggers
  logic halted, flush_wr, cmd_wr, addr_wr, data_wr, data_rd, active;
  assign halted = cpu_halted_i & ~run_halted; // R3
  assign flush_wr = wr_to(IDX_SEC) & wd[SEC_FLUSH_BIT];
  // triggers pass only when the host runs and is not frozen
  assign active = host_en & ~halted & ~flush_wr; // R11 R3
  assign cmd_wr = wr_to(IDX_SEC) && (wd[1:0] != CMD_NONE); // R17
  assign addr_wr = wr_to(IDX_ADDR);
  assign data_wr = wr_to(IDX_DATA);
  assign data_rd = acc_rd && (idx == IDX_DATA);

  // ==========================================================
  // bus line synchronisers and condition detect
  logic scl_m, scl_s, scl_p, sda_m, sda_s, sda_p;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_p <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_p <= 1'b1;
    end else begin
      scl_m <= scl_i;
      scl_s <= scl_m;
      scl_p <= scl_s;
      sda_m <= sda_i;
      sda_s <= sda_m;
      sda_p <= sda_s;
    end
  end

  logic start_det, stop_det, line_chg;
  assign start_det = scl_s & scl_p & sda_p & ~sda_s;
  assign stop_det = scl_s & scl_p & ~sda_p & sda_s;
  assign line_chg = (scl_s ^ scl_p) | (sda_s ^ sda_p);

  // ==========================================================
  // inactive-bus supervisor
  function automatic logic [15:0] to_limit(input logic [1:0] sel);
    case (sel)
      2'h1: to_limit = 16'(TO1_CYCLES); // R9
      2'h2: to_limit = 16'(TO2_CYCLES);
      2'h3: to_limit = 16'(TO3_CYCLES);
      default: to_limit = 16'hffff;
    endcase
  endfunction

  logic [15:0] idle_cnt;
  logic to_hit;
  assign to_hit = (to_sel != 2'h0) && (idle_cnt >= to_limit(to_sel)); // R8

  // counter saturates so a long quiet bus cannot wrap into a miss
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      idle_cnt <= 16'h0000;
    end else if (line_chg || !host_en || flush_wr) begin
      idle_cnt <= 16'h0000;
    end else if (!halted && !to_hit) begin
      idle_cnt <= idle_cnt + 16'h0001;
    end
  end

  // ==========================================================
  // bus state tracking
  logic owner_q;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      bus_state_o <= BUS_UNKNOWN;
    end else if (!host_en) begin
      bus_state_o <= BUS_UNKNOWN;
    end else if (flush_wr) begin
      bus_state_o <= BUS_IDLE; // R12
    end else if (wr_to(IDX_STAT) && wd[1:0] == BUS_IDLE) begin
      bus_state_o <= BUS_IDLE;
    end else if (halted) begin
      bus_state_o <= bus_state_o;
    end else if (stop_det) begin
      bus_state_o <= BUS_IDLE;
    end else if (start_det) begin
      bus_state_o <= owner_q ? BUS_OWNER : BUS_BUSY;
    end else if (to_hit && bus_state_o != BUS_IDLE) begin
      bus_state_o <= BUS_IDLE; // R8
    end
  end

  // ==========================================================
  // pending address start: waits for a free bus and high scl
  logic addr_pend, can_start;
  assign can_start = addr_pend && scl_s &&
    (bus_state_o == BUS_IDLE || bus_state_o == BUS_OWNER); // R14

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      addr_pend <= 1'b0;
    end else if (!host_en || flush_wr) begin
      addr_pend <= 1'b0; // R12
    end else if (addr_wr && !halted) begin
      addr_pend <= 1'b1; // R21
    end else if (active && can_start && !cmd_wr && !data_wr &&
                 !(data_rd && smart_en)) begin
      addr_pend <= 1'b0;
    end
  end

  // ownership: set by our own start, dropped at stop or flush
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      owner_q <= 1'b0;
    end else if (!host_en || flush_wr || stop_det) begin
      owner_q <= 1'b0;
    end else if (op_valid_o && op_o.code == OP_START_ADDR) begin
      owner_q <= 1'b1;
    end
  end

  // ==========================================================
  // operation issue to the bit engine
  // software triggers win over a pending start, which just waits
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      op_valid_o <= 1'b0;
      op_o <= '0;
    end else begin
      op_valid_o <= 1'b0;
      if (!active) begin
        op_valid_o <= 1'b0; // R11 R3
      end else if (cmd_wr) begin
        op_valid_o <= 1'b1;
        op_o.ack <= wd[SEC_ACK_BIT]; // R20 R16
        op_o.data <= addr_q;
        case (wd[1:0])
          CMD_CMD_REPEATED_START: op_o.code <= OP_ACK_CMD_REPEATED_START; // R18
          CMD_STOP: op_o.code <= OP_ACK_STOP; // R18 R7
          // read direction acks then reads, write skips the ack
          default: begin
            op_o.code <= addr_q[0] ? OP_ACK_READ : OP_WRITE; // R19
            op_o.ack <= addr_q[0] & wd[SEC_ACK_BIT]; // R19 R16
          end
        endcase
      end else if (data_wr) begin
        op_valid_o <= 1'b1;
        op_o.code <= OP_WRITE; // R16
        op_o.ack <= 1'b0;
        op_o.data <= wd;
      end else if (data_rd && smart_en) begin
        op_valid_o <= 1'b1;
        op_o.code <= OP_ACK_ONLY; // R10 R16
        op_o.ack <= ack_sel; // R15
      end else if (can_start) begin
        op_valid_o <= 1'b1;
        op_o.code <= OP_START_ADDR; // R21 R14
        op_o.ack <= 1'b0;
        op_o.data <= addr_q;
      end
    end
  end

  // ==========================================================
  // completion flags: a set in the clearing cycle wins
  logic qc_rd, rd_set, wr_set, flag_clr, rd_flag, wr_flag;
  assign qc_rd = qc_en & eng_evt_i.addr_done & eng_evt_i.addr_acked &
    addr_q[0]; // R6
  assign rd_set = ~halted & (eng_evt_i.rd_done | qc_rd); // R22 R6
  assign wr_set = ~halted & (eng_evt_i.wr_done |
    (eng_evt_i.addr_done & ~qc_rd)); // R22
  assign flag_clr = addr_wr | data_wr | data_rd | cmd_wr | flush_wr;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rd_flag <= 1'b0;
      wr_flag <= 1'b0;
    end else begin
      if (rd_set) begin
        rd_flag <= 1'b1;
      end else if (flag_clr || (wr_to(IDX_STAT) && wd[STAT_RIF_BIT])) begin
        rd_flag <= 1'b0;
      end
      if (wr_set) begin
        wr_flag <= 1'b1;
      end else if (flag_clr || (wr_to(IDX_STAT) && wd[STAT_WIF_BIT])) begin
        wr_flag <= 1'b0;
      end
    end
  end

  // ==========================================================
  // registered level outputs
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      read_irq_o <= 1'b0;
      write_irq_o <= 1'b0;
      host_enable_o <= 1'b0;
      dual_enable_o <= 1'b0;
      client_plus_speed_o <= 1'b0;
    end else begin
      read_irq_o <= rd_flag & read_irq_enable & global_irq_en_i; // R4 R23
      write_irq_o <= wr_flag & write_irq_enable & global_irq_en_i; // R5 R23
      host_enable_o <= host_en & ~flush_wr; // R13
      dual_enable_o <= dual_en; // R2
      client_plus_speed_o <= dual_en & plus_sel; // R1
    end
  end

  // ==========================================================
  // Avalon slave: one wait cycle, then the answer
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      avs_waitrequest_o <= 1'b1;
    end else if ((avs_read_i || avs_write_i) && avs_waitrequest_o) begin
      avs_waitrequest_o <= 1'b0;
    end else begin
      avs_waitrequest_o <= 1'b1;
    end
  end

  // read data captured while waitrequest is still high
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (avs_read_i && avs_waitrequest_o) begin
      case (idx)
        IDX_DUAL: avs_readdata_o <= {30'h0, plus_sel, dual_en};
        IDX_DBG: avs_readdata_o <= {31'h0, run_halted};
        IDX_PRIM: avs_readdata_o <= {24'h0, read_irq_enable, write_irq_enable, 1'b0, qc_en,
          to_sel, smart_en, host_en};
        IDX_SEC: avs_readdata_o <= {29'h0, ack_sel, 2'b00}; // R17
        IDX_STAT: avs_readdata_o <= {24'h0, rd_flag, wr_flag, 4'h0,
          bus_state_o};
        IDX_ADDR: avs_readdata_o <= {24'h0, addr_q};
        IDX_DATA: avs_readdata_o <= {24'h0, eng_evt_i.rx_byte};
        default: avs_readdata_o <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_flush_req;
    flush_wr && host_en;
  endsequence
  sequence s_flush_seen;
    !host_enable_o ##1 host_enable_o;
  endsequence

  property p_plus_gated;
    wr_to(IDX_DUAL) && !wd[DUAL_EN_BIT] |=> ##1 !client_plus_speed_o;
  endproperty
  a_plus_gated: assert property (p_plus_gated) // R1
    else $error("plus speed active without dual mode");

  property p_dual_on;
    wr_to(IDX_DUAL) && wd[DUAL_EN_BIT] |=> ##1 dual_enable_o;
  endproperty
  a_dual_on: assert property (p_dual_on) // R2
    else $error("dual mode not enabled after write");

  property p_halt_quiet;
    halted |=> !op_valid_o;
  endproperty
  a_halt_quiet: assert property (p_halt_quiet) // R3
    else $error("operation issued while halted");

  property p_rd_irq;
    read_irq_o |-> $past(rd_flag) && $past(read_irq_enable) && $past(global_irq_en_i);
  endproperty
  a_rd_irq: assert property (p_rd_irq) // R4
    else $error("read irq without its causes");

  property p_wr_irq;
    wr_flag && write_irq_enable && global_irq_en_i |=> write_irq_o;
  endproperty
  a_wr_irq: assert property (p_wr_irq) // R5
    else $error("write irq missing");

  property p_quick;
    qc_rd && !halted |=> rd_flag;
  endproperty
  a_quick: assert property (p_quick) // R6
    else $error("quick command read flag not set");

  property p_timeout;
    to_hit && host_en && !flush_wr && !halted && !start_det &&
      !stop_det && !wr_to(IDX_STAT) |=> bus_state_o == BUS_IDLE;
  endproperty
  a_timeout: assert property (p_timeout) // R8
    else $error("timeout did not idle the bus");

  property p_smart;
    data_rd && smart_en && active && !cmd_wr && !data_wr |=>
      op_valid_o && op_o.code == OP_ACK_ONLY && op_o.ack == $past(ack_sel);
  endproperty
  a_smart: assert property (p_smart) // R10
    else $error("smart read gave no ack action");

  property p_off_quiet;
    !host_en |=> !op_valid_o;
  endproperty
  a_off_quiet: assert property (p_off_quiet) // R11
    else $error("operation with host disabled");

  property p_flush;
    s_flush_req |=> bus_state_o == BUS_IDLE && !addr_pend;
  endproperty
  a_flush: assert property (p_flush) // R12
    else $error("flush left state behind");

  property p_flush_pulse;
    s_flush_req |=> s_flush_seen;
  endproperty
  a_flush_pulse: assert property (p_flush_pulse) // R13
    else $error("flush pulse wrong");

  property p_no_ack_on_write;
    op_valid_o && op_o.code == OP_WRITE |-> !op_o.ack;
  endproperty
  a_no_ack_on_write: assert property (p_no_ack_on_write) // R16
    else $error("ack action on data write");

  property p_cmd_zero;
    avs_read_i && avs_waitrequest_o && idx == IDX_SEC |=>
      avs_readdata_o[1:0] == 2'b00;
  endproperty
  a_cmd_zero: assert property (p_cmd_zero) // R17
    else $error("command field read nonzero");

  property p_stop_cmd;
    cmd_wr && active && wd[1:0] == CMD_STOP |=>
      op_valid_o && op_o.code == OP_ACK_STOP &&
      op_o.ack == $past(wd[SEC_ACK_BIT]);
  endproperty
  a_stop_cmd: assert property (p_stop_cmd) // R18
    else $error("stop command not issued");

  property p_rd_done;
    eng_evt_i.rd_done && !halted |=> rd_flag;
  endproperty
  a_rd_done: assert property (p_rd_done) // R22
    else $error("read flag lost");

endmodule

// file: sim/twhc_engine_model.sv
// Purpose: bit engine and client stand-in for twhc_top
// Assumes: link clock 125 ns inside frames, lines pulled high
// Notes: frames run one at a time; answers after 1 to 5 clocks
`timescale 1ns/1ps
module twhc_engine_model
  import twhc_pkg::*;
#(
  parameter logic [7:0] RX_BYTE = 8'h3c
) (
  input wire logic clk_i,
  input wire logic op_valid_i,
  input wire twhc_op_t op_i,
  output twhc_evt_t evt_o,
  output logic scl_o,
  output logic sda_o
);
  bit busy;
  // ========================================
  // frames, serialised so two ops never fight on the lines
  task automatic serve(input twhc_op_t op);
    while (busy) @(posedge clk_i);
    busy = 1'b1;
    // sda is set up while scl is low, so the line levels left by the
    // previous frame never show up as a false start or stop
    if (op.code inside {OP_START_ADDR, OP_ACK_CMD_REPEATED_START, OP_ACK_STOP}) begin
      scl_o = 1'b0;
      sda_o = (op.code != OP_ACK_STOP);
      #62.5 scl_o = 1'b1;
      #62.5 sda_o = (op.code == OP_ACK_STOP);
    end
    if (!(op.code inside {OP_ACK_STOP, OP_ACK_ONLY})) begin
      repeat (2) begin
        #62.5 scl_o = 1'b0;
        #62.5 scl_o = 1'b1;
      end
    end
    repeat (1 + $urandom_range(4)) @(posedge clk_i);
    // client always acks the address here
    evt_o <= {op.code == OP_START_ADDR, 1'b1, op.code == OP_WRITE,
              op.code == OP_ACK_READ, RX_BYTE};
    @(posedge clk_i);
    evt_o <= {4'h0, RX_BYTE};
    busy = 1'b0;
  endtask
  initial begin
    evt_o = {4'h0, RX_BYTE};
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  always @(posedge clk_i) begin
    if (op_valid_i === 1'b1) begin
      fork
        serve(op_i);
      join_none
    end
  end
endmodule

// file: sim/test_two_wire_host_control.sv
// Purpose: self-checking bench for twhc_top
// Assumes: timeout limits shrunk to 20/40/80 clocks
// Notes: expected ops queue in exp_q, a monitor matches them
`timescale 1ns/1ps
module test_two_wire_host_control;
  import twhc_pkg::*;
  localparam logic [7:0] RXB = 8'h5a;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] adr = 8'h00;
  logic rd_s = 1'b0;
  logic wr_s = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [3:0] be = 4'h1;
  logic halt = 1'b0;
  logic gie = 1'b0;
  logic [31:0] rdat;
  logic wait_s, scl, sda, op_v, hen, den, plus, rirq, wirq;
  logic [1:0] bst;
  twhc_evt_t evt;
  twhc_op_t op;
  int fail_count = 0;
  int checks_done = 0;
  logic [13:0] exp_q [$];
  logic [13:0] e;
  int lim [4] = '{0, 20, 40, 80};
  logic [5:0] ridx [6] = '{IDX_DUAL, IDX_DBG, IDX_PRIM, IDX_SEC,
                           IDX_STAT, 6'h3f};
  always #4 clk_i = ~clk_i;
  twhc_top #(.TO1_CYCLES(20), .TO2_CYCLES(40), .TO3_CYCLES(80))
    twhc_top_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .avs_address_i(adr), .avs_read_i(rd_s), .avs_write_i(wr_s),
    .avs_writedata_i(wdat), .avs_byteenable_i(be),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wait_s), .scl_i(scl),
    .sda_i(sda), .cpu_halted_i(halt), .global_irq_en_i(gie),
    .eng_evt_i(evt), .op_o(op), .op_valid_o(op_v),
    .host_enable_o(hen), .dual_enable_o(den),
    .client_plus_speed_o(plus), .read_irq_o(rirq),
    .write_irq_o(wirq), .bus_state_o(bst));
  twhc_engine_model #(.RX_BYTE(RXB)) twhc_engine_model_inst (
    .clk_i(clk_i), .op_valid_i(op_v), .op_i(op), .evt_o(evt),
    .scl_o(scl), .sda_o(sda));
  // ========================================
  // checking and closing
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic hang();
    fail_count++;
    stop_test();
  endtask
  task automatic tick();
    repeat (2) @(posedge clk_i);
    #1;
  endtask
  // ========================================
  // register bus master: hold until waitrequest seen low
  task automatic xfer(input bit w, input logic [5:0] idx,
                      input logic [7:0] d, output logic [7:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    adr <= {idx, 2'b00};
    wr_s <= w;
    rd_s <= !w;
    wdat <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wait_s !== 1'b0 && n < 50);
    if (wait_s !== 1'b0)
      hang();
    r = rdat[7:0];
    wr_s <= 1'b0;
    rd_s <= 1'b0;
    tick();
  endtask
  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    logic [7:0] r;
    xfer(1'b1, idx, d, r);
  endtask
  task automatic rdc(input logic [5:0] idx, input logic [7:0] x,
                     input logic [7:0] m);
    logic [7:0] r;
    xfer(1'b0, idx, 8'h00, r);
    check(32'(r & m), 32'(x & m));
  endtask
  // bounded wait for any engine completion pulse
  task automatic wait_evt();
    int n;
    n = 0;
    while (!(evt.addr_done | evt.wr_done | evt.rd_done) && n < 300) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 300)
      hang();
    repeat (3) @(posedge clk_i);
    #1;
  endtask
  task automatic start_addr(input logic [7:0] a);
    wr(IDX_STAT, 8'h01);
    exp_q.push_back({2'b01, OP_START_ADDR, 1'b0, a});
    wr(IDX_ADDR, a);
    wait_evt();
  endtask
  // ========================================
  // op monitor: every op must match the oldest note
  always @(posedge clk_i) begin
    if (rst_n_i && op_v === 1'b1) begin
      if (exp_q.size() == 0) begin
        check(32'(op.code), 32'h0);
      end else begin
        e = exp_q.pop_front();
        check(32'(op.code), 32'(e[11:9]));
        if (e[13]) check(32'(op.ack), 32'(e[8]));
        if (e[12]) check(32'(op.data), 32'(e[7:0]));
      end
    end
  end
  initial begin
    repeat (90000) @(posedge clk_i);
    hang();
  end
  // ========================================
  // main sequence
  initial begin
    logic [7:0] d;
    logic k, dr;
    int n, lows;
    n = $urandom(701);
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    foreach (ridx[i]) rdc(ridx[i], 8'h00, 8'hff);
    be <= 4'h0;
    wr(IDX_PRIM, 8'hff);
    be <= 4'h1;
    rdc(IDX_PRIM, 8'h00, 8'hff);
    wr(IDX_DATA, 8'h11);
    wr(IDX_DUAL, 8'h02);
    check(32'({den, plus}), 32'h0);
    wr(IDX_DUAL, 8'h03);
    check(32'({den, plus}), 32'h3);
    rdc(IDX_DUAL, 8'h03, 8'hff);
    wr(IDX_PRIM, 8'h41);
    gie <= 1'b1;
    check(32'(hen), 32'h1);
    start_addr(8'($urandom) & 8'hfe);
    rdc(IDX_STAT, 8'h40, 8'hc0);
    check(32'({rirq, wirq}), 32'h1);
    gie <= 1'b0;
    tick();
    check(32'(wirq), 32'h0);
    gie <= 1'b1;
    d = 8'($urandom);
    exp_q.push_back({2'b11, OP_WRITE, 1'b0, d});
    wr(IDX_DATA, d);
    wait_evt();
    rdc(IDX_STAT, 8'h40, 8'hc0);
    for (int dir = 0; dir < 2; dir++) begin
      dr = 1'(dir);
      start_addr({7'($urandom), dr});
      for (int c = 0; c < 4; c++) begin
        k = 1'($urandom);
        if (c == 2)
          exp_q.push_back({2'b10, dr ? OP_ACK_READ : OP_WRITE, dr & k,
                           8'h00});
        else if (c != 0)
          exp_q.push_back({2'b10, c == 1 ? OP_ACK_CMD_REPEATED_START : OP_ACK_STOP,
                           k, 8'h00});
        wr(IDX_SEC, {5'h0, k, 2'(c)});
        if (c == 2)
          wait_evt();
      end
      rdc(IDX_SEC, {5'h0, k, 2'h0}, 8'hff);
    end
    // smart mode: data read alone sends the stored choice
    wr(IDX_PRIM, 8'h43);
    wr(IDX_SEC, 8'h04);
    exp_q.push_back({2'b10, OP_ACK_ONLY, 1'b1, 8'h00});
    rdc(IDX_DATA, RXB, 8'hff);
    wr(IDX_PRIM, 8'h41);
    rdc(IDX_DATA, RXB, 8'hff);
    // quick command, read direction
    wr(IDX_PRIM, 8'h91);
    start_addr(8'h35);
    rdc(IDX_STAT, 8'h80, 8'hc0);
    check(32'({rirq, wirq}), 32'h2);
    gie <= 1'b0;
    tick();
    check(32'(rirq), 32'h0);
    gie <= 1'b1;
    exp_q.push_back({2'b10, OP_ACK_STOP, 1'b0, 8'h00});
    wr(IDX_SEC, 8'h03);
    rdc(IDX_STAT, 8'h00, 8'hc0);
    // halted processor: dropped unless run bit set
    halt <= 1'b1;
    wr(IDX_DATA, 8'h77);
    wr(IDX_DBG, 8'h01);
    exp_q.push_back({2'b11, OP_WRITE, 1'b0, 8'h78});
    wr(IDX_DATA, 8'h78);
    wait_evt();
    wr(IDX_DBG, 8'h00);
    halt <= 1'b0;
    // flush strobe: zero does nothing, one drops enable one clock
    for (int f = 0; f < 2; f++) begin
      start_addr(8'h52);
      lows = 0;
      fork
        repeat (12) begin
          @(posedge clk_i);
          lows += int'(hen === 1'b0);
        end
        wr(IDX_SEC, {4'h0, 1'(f), 3'h0});
      join
      check(32'(lows), 32'(f));
      if (f == 1) rdc(IDX_STAT, 8'h01, 8'hc3);
    end
    // inactive bus supervisor, every timeout code
    for (int t = 0; t < 4; t++) begin
      wr(IDX_PRIM, {4'h0, 2'(t), 2'b01});
      start_addr(8'h20);
      n = 0;
      while (bst !== BUS_IDLE && n < 120) begin
        @(posedge clk_i);
        n++;
      end
      if (t == 0) check(32'(bst), 32'(BUS_OWNER));
      else check(32'(n >= lim[t] - 12 && n <= lim[t] + 6), 32'h1);
    end
    repeat (20) @(posedge clk_i);
    check(32'(exp_q.size()), 32'h0);
    stop_test();
  end
endmodule
